// >>> hdl/pti_pkg.sv
// types shared by the proximity register block
package pti_pkg;

  // serial link states, one-hot
  typedef enum logic [5:0] {
    PTI_ST_IDLE = 6'h01,
    PTI_ST_RECV = 6'h02,
    PTI_ST_ACK  = 6'h04,
    PTI_ST_SEND = 6'h08,
    PTI_ST_RACK = 6'h10,
    PTI_ST_SKIP = 6'h20
  } pti_state_t;

  // which byte of a transaction is being received
  typedef enum logic [2:0] {
    PTI_BY_ADDR = 3'h1,
    PTI_BY_CMD  = 3'h2,
    PTI_BY_DATA = 3'h4
  } pti_byte_t;

  // conversion result from the converter, same clock
  typedef struct packed {
    logic        done;
    logic [11:0] value;
  } pti_conv_t;

  // configuration presented to the analog front end
  typedef struct packed {
    logic [7:0] shutdown;
    logic [7:0] burst;
    logic [7:0] interval;
  } pti_cfg_t;

endpackage

// >>> hdl/pti_regs.svh
// register offsets, field positions, reset values and command bits of the proximity register block
`ifndef PTI_REGS_SVH
`define PTI_REGS_SVH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define PTI_OFS_SHUTDOWN   4'h0
`define PTI_OFS_BURST_CFG  4'h1
`define PTI_OFS_INTERVAL   4'h2
`define PTI_OFS_THR_LOW    4'h3
`define PTI_OFS_THR_UPPER  4'h4
`define PTI_OFS_RES_LOW    4'h5
`define PTI_OFS_RES_UPPER  4'h6
`define PTI_OFS_EVENT      4'h7

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define PTI_RST_SHUTDOWN   8'h00
`define PTI_RST_BURST_CFG  8'h96
`define PTI_RST_INTERVAL   8'h00
`define PTI_RST_ZERO       8'h00

// ----------------------------------------------------------------------------
// event register fields
// ----------------------------------------------------------------------------
`define PTI_EV_FALL        6
`define PTI_EV_RISE        5
`define PTI_EV_DONE        4
`define PTI_EV_THR_EN      1
`define PTI_EV_DONE_EN     0

// ----------------------------------------------------------------------------
// command byte fields
// ----------------------------------------------------------------------------
`define PTI_CMD_SEL        7
`define PTI_CMD_CLR_THR    6
`define PTI_CMD_CLR_DONE   5
`define PTI_CMD_SOFT_RST   4

// ----------------------------------------------------------------------------
// serial link
// ----------------------------------------------------------------------------
`define PTI_SLAVE_ADDR     7'h55
`define PTI_BITS_PER_BYTE  4'h8

`endif

// >>> hdl/pti_regs_top.sv
// proximity sensor register file, threshold comparator, event flags and serial slave
`timescale 1ns/1ps
`include "pti_regs.svh"
// Function
// - threshold upper nibble kept in bits 3:0
// - result low byte, read only
// - result upper nibble, read only, rest zero
// - falling flag in event bit 6
// - rising flag in event bit 5
// - conversion done flag in event bit 4
// - comparator rising edge sets rising flag
// - comparator falling edge sets falling flag
// - command bit 6 clears both threshold flags
// - command bit 5 clears done flag
// - event bit 1 gates threshold onto pin
// - event bit 0 gates done onto pin
// - burst and interval registers load defaults
// - select bit set, low nibble addresses
// - command bit 4 restores all defaults
module pti_regs_top #(
  parameter logic [6:0] SLAVE_ADDR = `PTI_SLAVE_ADDR,
  parameter int         RES_W      = 12
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // serial link pins
  input  wire logic             scl_in,
  input  wire logic             sda_in,
  output logic                  sda_out,
  output logic                  sda_oe,
  // converter
  input  wire pti_pkg::pti_conv_t conv,
  // front end configuration and interrupt pin
  output pti_pkg::pti_cfg_t     cfg,
  output logic                  irq_n
);

  // ----------------------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------------------
  if (RES_W != 12) begin : g_bad_width
    $error("pti_regs_top: result width must be 12");
  end

  // ----------------------------------------------------------------------------
  // pin synchronisers and edge detection
  // ----------------------------------------------------------------------------
  logic [2:0] scl_q;
  logic [2:0] sda_q;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_det;
  logic       stop_det;

  // first stage is only read by the second; the third stage serves edge detection
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q <= 3'h7;
      sda_q <= 3'h7;
    end else begin
      scl_q <= {scl_q[1:0], scl_in};
      sda_q <= {sda_q[1:0], sda_in};
    end
  end

  assign scl_rise  = scl_q[1] & ~scl_q[2];
  assign scl_fall  = ~scl_q[1] & scl_q[2];
  assign start_det = scl_q[1] & scl_q[2] & ~sda_q[1] & sda_q[2];
  assign stop_det  = scl_q[1] & scl_q[2] & sda_q[1] & ~sda_q[2];

  // ----------------------------------------------------------------------------
  // serial slave
  // ----------------------------------------------------------------------------
  pti_pkg::pti_state_t state_q;
  pti_pkg::pti_byte_t  byte_q;
  logic [3:0]          bitcnt_q;
  logic [7:0]          shift_q;
  logic                rd_q;
  logic                nack_q;
  logic [3:0]          ptr_q;
  logic                cmd_stb;
  logic                wr_stb;
  logic [7:0]          rd_data;

  // a received byte is acted on at the falling clock edge that ends its eighth bit
  assign cmd_stb = (state_q == pti_pkg::PTI_ST_RECV) && scl_fall && (bitcnt_q == `PTI_BITS_PER_BYTE)
                   && (byte_q == pti_pkg::PTI_BY_CMD);
  assign wr_stb  = (state_q == pti_pkg::PTI_ST_RECV) && scl_fall && (bitcnt_q == `PTI_BITS_PER_BYTE)
                   && (byte_q == pti_pkg::PTI_BY_DATA);

  // byte engine; start and stop take priority over any bit activity
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q  <= pti_pkg::PTI_ST_IDLE;
      byte_q   <= pti_pkg::PTI_BY_ADDR;
      bitcnt_q <= 4'h0;
      shift_q  <= 8'h00;
      rd_q     <= 1'b0;
      nack_q   <= 1'b0;
      sda_oe   <= 1'b0;
    end else if (start_det) begin
      state_q  <= pti_pkg::PTI_ST_RECV;
      byte_q   <= pti_pkg::PTI_BY_ADDR;
      bitcnt_q <= 4'h0;
      sda_oe   <= 1'b0;
    end else if (stop_det) begin
      state_q <= pti_pkg::PTI_ST_IDLE;
      sda_oe  <= 1'b0;
    end else begin
      unique case (state_q)
        pti_pkg::PTI_ST_IDLE: begin
          sda_oe <= 1'b0;
        end
        pti_pkg::PTI_ST_RECV: begin
          if (scl_rise) begin
            shift_q  <= {shift_q[6:0], sda_q[1]};
            bitcnt_q <= bitcnt_q + 4'h1;
          end else if (scl_fall && bitcnt_q == `PTI_BITS_PER_BYTE) begin
            bitcnt_q <= 4'h0;
            if (byte_q == pti_pkg::PTI_BY_ADDR && shift_q[7:1] != SLAVE_ADDR) begin
              state_q <= pti_pkg::PTI_ST_SKIP; // not ours: stay off the line until stop or a repeated start
            end else begin
              state_q <= pti_pkg::PTI_ST_ACK;
              sda_oe  <= 1'b1;
              if (byte_q == pti_pkg::PTI_BY_ADDR) begin
                rd_q <= shift_q[0];
              end
              byte_q <= (byte_q == pti_pkg::PTI_BY_ADDR) ? pti_pkg::PTI_BY_CMD : pti_pkg::PTI_BY_DATA;
            end
          end
        end
        pti_pkg::PTI_ST_ACK: begin
          if (scl_fall) begin
            if (rd_q) begin
              state_q <= pti_pkg::PTI_ST_SEND;
              shift_q <= rd_data;
              sda_oe  <= ~rd_data[7];
            end else begin
              state_q <= pti_pkg::PTI_ST_RECV;
              sda_oe  <= 1'b0;
            end
          end
        end
        pti_pkg::PTI_ST_SEND: begin
          if (scl_rise) begin
            bitcnt_q <= bitcnt_q + 4'h1;
          end else if (scl_fall) begin
            if (bitcnt_q == `PTI_BITS_PER_BYTE) begin
              state_q  <= pti_pkg::PTI_ST_RACK;
              bitcnt_q <= 4'h0;
              sda_oe   <= 1'b0;
            end else begin
              shift_q <= {shift_q[6:0], 1'b0};
              sda_oe  <= ~shift_q[6];
            end
          end
        end
        pti_pkg::PTI_ST_RACK: begin
          if (scl_rise) begin
            nack_q <= sda_q[1];
          end else if (scl_fall) begin
            if (nack_q) begin
              state_q <= pti_pkg::PTI_ST_SKIP;
            end else begin
              state_q <= pti_pkg::PTI_ST_SEND; // repeated reads return the same register
              shift_q <= rd_data;
              sda_oe  <= ~rd_data[7];
            end
          end
        end
        pti_pkg::PTI_ST_SKIP: begin
          sda_oe <= 1'b0;
        end
        default: begin
          state_q <= pti_pkg::PTI_ST_IDLE;
          sda_oe  <= 1'b0;
        end
      endcase
    end
  end

  // open drain: the pin is only ever pulled low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------------------
  logic soft_rst;
  logic clr_thr;
  logic clr_done;

  assign soft_rst = cmd_stb & shift_q[`PTI_CMD_SOFT_RST];
  assign clr_thr  = cmd_stb & shift_q[`PTI_CMD_CLR_THR];
  assign clr_done = cmd_stb & shift_q[`PTI_CMD_CLR_DONE];

  // pointer moves only when the select bit is set or on a soft reset, which zeroes it; clear-only bytes leave it alone
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_q <= 4'h0;
    end else if (soft_rst) begin
      ptr_q <= 4'h0;
    end else if (cmd_stb && shift_q[`PTI_CMD_SEL]) begin
      ptr_q <= shift_q[3:0];
    end
  end

  // ----------------------------------------------------------------------------
  // writable registers
  // ----------------------------------------------------------------------------
  logic [7:0] thr_low_q;
  logic [3:0] thr_up_q;
  logic [1:0] ev_en_q;

  // soft reset and power up give the same defaults
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg.shutdown <= `PTI_RST_SHUTDOWN;
      cfg.burst    <= `PTI_RST_BURST_CFG;
      cfg.interval <= `PTI_RST_INTERVAL;
      thr_low_q    <= `PTI_RST_ZERO;
      thr_up_q     <= 4'h0;
      ev_en_q      <= 2'h0;
    end else if (soft_rst) begin
      cfg.shutdown <= `PTI_RST_SHUTDOWN;
      cfg.burst    <= `PTI_RST_BURST_CFG;
      cfg.interval <= `PTI_RST_INTERVAL;
      thr_low_q    <= `PTI_RST_ZERO;
      thr_up_q     <= 4'h0;
      ev_en_q      <= 2'h0;
    end else if (wr_stb) begin
      unique case (ptr_q)
        `PTI_OFS_SHUTDOWN:  cfg.shutdown <= shift_q;
        `PTI_OFS_BURST_CFG: cfg.burst    <= shift_q;
        `PTI_OFS_INTERVAL:  cfg.interval <= shift_q;
        `PTI_OFS_THR_LOW:   thr_low_q    <= shift_q;
        `PTI_OFS_THR_UPPER: thr_up_q     <= shift_q[3:0];
        `PTI_OFS_EVENT:     ev_en_q      <= shift_q[`PTI_EV_THR_EN:`PTI_EV_DONE_EN];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // result capture and comparator
  // ----------------------------------------------------------------------------
  logic [11:0] res_q;
  logic        cmp_q;
  logic        cmp_d;

  // result follows each completed conversion and a soft reset clears it; register writes never reach it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      res_q <= 12'h000;
    end else if (soft_rst) begin
      res_q <= 12'h000;
    end else if (conv.done) begin
      res_q <= conv.value;
    end
  end

  // compared every cycle, so a new threshold takes effect without a conversion
  assign cmp_d = res_q > {thr_up_q, thr_low_q};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmp_q <= 1'b0;
    end else if (soft_rst) begin
      cmp_q <= 1'b0; // restart with the cleared result so no false falling edge follows
    end else begin
      cmp_q <= cmp_d;
    end
  end

  // ----------------------------------------------------------------------------
  // event flags: a set in the same cycle as a clear wins
  // ----------------------------------------------------------------------------
  logic fall_q;
  logic rise_q;
  logic done_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else begin
      rise_q <= (cmp_d & ~cmp_q) | (rise_q & ~clr_thr & ~soft_rst);
      fall_q <= (~cmp_d & cmp_q) | (fall_q & ~clr_thr & ~soft_rst);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done_q <= 1'b0;
    end else begin
      done_q <= conv.done | (done_q & ~clr_done & ~soft_rst);
    end
  end

  // ----------------------------------------------------------------------------
  // read mux and interrupt pin
  // ----------------------------------------------------------------------------
  always_comb begin
    rd_data = 8'h00; // unmapped and reserved bits read zero
    unique case (ptr_q)
      `PTI_OFS_SHUTDOWN:  rd_data = cfg.shutdown;
      `PTI_OFS_BURST_CFG: rd_data = cfg.burst;
      `PTI_OFS_INTERVAL:  rd_data = cfg.interval;
      `PTI_OFS_THR_LOW:   rd_data = thr_low_q;
      `PTI_OFS_THR_UPPER: rd_data = {4'h0, thr_up_q};
      `PTI_OFS_RES_LOW:   rd_data = res_q[7:0];
      `PTI_OFS_RES_UPPER: rd_data = {4'h0, res_q[11:8]};
      `PTI_OFS_EVENT:     rd_data = {1'b0, fall_q, rise_q, done_q, 2'h0, ev_en_q};
      default:            rd_data = 8'h00;
    endcase
  end

  // active low pin, registered so it never glitches on the board
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_n <= 1'b1;
    end else begin
      irq_n <= ~((ev_en_q[1] & (rise_q | fall_q))
               | (ev_en_q[0] & done_q));
    end
  end

endmodule

// >>> verification/pti_host_model.sv
// bus master model standing in for the host controller
`timescale 1ns/1ps
`include "pti_regs.svh"
module pti_host_model (
  // clock
  input  wire logic clk,
  // bus lines; the data wire is pulled up
  input  wire logic sda_wire,
  output logic      scl,
  output logic      sda_low
);
  int nack_cnt = 0;

  // idle bus: both lines released
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // wait n edges, then step just past the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // one clock slot; lo is set while low, hi in mid-high so start and stop can be framed
  // eight system clocks a slot: 400 ns link period, data moves three clocks after the fall
  task automatic clk_slot(input logic lo, input logic hi, output logic r);
    scl = 1'b0;
    tick(3);
    sda_low = lo;
    tick(1);
    scl = 1'b1;
    tick(2);
    r = sda_wire;
    sda_low = hi;
    tick(2);
  endtask

  // eight bits msb first, then the acknowledge slot with the line released
  task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--)
      clk_slot(~tx[i], ~tx[i], rx[i]);
    clk_slot(1'b0, 1'b0, ack);
  endtask

  task automatic send(input logic [7:0] tx);
    logic [7:0] rx;
    logic       ack;
    byte_io(tx, rx, ack);
    if (ack !== 1'b0)
      nack_cnt++;
  endtask

  // register write; clear-only commands go without a data byte
  task automatic wr(input logic [7:0] cmd, input logic [7:0] data, input logic with_data);
    logic r;
    clk_slot(1'b0, 1'b1, r);
    send({`PTI_SLAVE_ADDR, 1'b0});
    send(cmd);
    if (with_data)
      send(data);
    clk_slot(1'b1, 1'b0, r);
  endtask

  // register read: command sets the pointer, repeated start, one byte, then refuse more
  task automatic rd(input logic [7:0] cmd, output logic [7:0] d);
    logic r;
    clk_slot(1'b0, 1'b1, r);
    send({`PTI_SLAVE_ADDR, 1'b0});
    send(cmd);
    clk_slot(1'b0, 1'b1, r);
    send({`PTI_SLAVE_ADDR, 1'b1});
    byte_io(8'hFF, d, r);
    clk_slot(1'b1, 1'b0, r);
  endtask
endmodule

// >>> verification/pti_regs_props.sv
// pin-level assertions for the proximity register block
`timescale 1ns/1ps
module pti_regs_props (
  // clock and reset
  input wire logic               clk,
  input wire logic               rst_n,
  // serial link pins
  input wire logic               scl_in,
  input wire logic               sda_in,
  input wire logic               sda_out,
  input wire logic               sda_oe,
  // converter, front end and interrupt
  input wire pti_pkg::pti_conv_t conv,
  input wire pti_pkg::pti_cfg_t  cfg,
  input wire logic               irq_n
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  logic       scl_q;
  logic [7:0] link_age_q;
  logic [7:0] conv_age_q;

  // ------------------------------------------------------------
  // cause tracking
  // ------------------------------------------------------------
  // ages since the last clock-line edge and the last conversion; saturating so idle time never wraps
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q      <= 1'b1;
      link_age_q <= 8'h00;
      conv_age_q <= 8'hFF;
    end else begin
      scl_q      <= scl_in;
      link_age_q <= (scl_in != scl_q) ? 8'h00 : link_age_q + {7'h00, link_age_q != 8'hFF};
      conv_age_q <= conv.done ? 8'h00 : conv_age_q + {7'h00, conv_age_q != 8'hFF};
    end
  end

  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  sequence s_ack_start;
    $rose(sda_oe);
  endsequence
  sequence s_ack_hold;
    sda_oe [*8];
  endsequence

  a_reset_defaults: assert property ($rose(rst_n) |-> irq_n && !sda_oe && cfg == {8'h00, 8'h96, 8'h00})
    else $error("reset values wrong");
  a_drive_low: assert property (sda_out == 1'b0)
    else $error("data pin driven high");
  a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in && !$past(scl_in, 2))
    else $error("data drive moved while clock high");
  a_ack_holds: assert property (s_ack_start |-> s_ack_hold)
    else $error("data drive too short");
  a_cfg_by_link: assert property ($changed(cfg) |-> link_age_q < 8'h0C)
    else $error("configuration changed without a write");
  a_irq_fall_cause: assert property ($fell(irq_n) |-> link_age_q < 8'h0C || conv_age_q < 8'h06)
    else $error("interrupt asserted without cause");
  a_irq_rise_cause: assert property ($rose(irq_n) |-> link_age_q < 8'h0C)
    else $error("interrupt dropped without command");
  a_idle_release: assert property (link_age_q > 8'h10 |-> !sda_oe)
    else $error("data line held while bus idle");
endmodule

bind pti_regs_top pti_regs_props u_props (.clk(clk), .rst_n(rst_n), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .conv(conv), .cfg(cfg), .irq_n(irq_n));

// >>> verification/pti_regs_top_tb.sv
// self-checking bench for the proximity register block
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin bad_count++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module pti_regs_top_tb;
  logic               clk = 1'b0;
  logic               rst_n, scl, h_low, sda_oe, sda_out, irq_n;
  wire logic          sda_w;
  pti_pkg::pti_conv_t conv;
  pti_pkg::pti_cfg_t  cfg;
  int                 bad_count = 0, compares = 0, cyc = 0;
  int                 thr, res, fl, rs, dn, en, cmp;
  int                 mr[16];
  int                 seed = 32'h0068;
  int                 vals[$];
  logic [7:0]         d;

  // open-drain wire: low if either side pulls
  assign sda_w = ~(sda_oe | h_low);
  always #25 clk = ~clk;

  pti_regs_top u_dut (.clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out),
    .sda_oe(sda_oe), .conv(conv), .cfg(cfg), .irq_n(irq_n));
  pti_host_model u_host (.clk(clk), .sda_wire(sda_w), .scl(scl), .sda_low(h_low));

  // ------------------------------------------------------------
  // reference model
  // ------------------------------------------------------------
  task automatic m_rst;
    foreach (mr[i]) mr[i] = 0;
    mr[1] = 8'h96;
    res = 0;
    fl = 0;
    rs = 0;
    dn = 0;
    en = 0;
    cmp = 0;
    thr = 0;
  endtask
  // edges of the strict compare set the flags; a steady level sets none
  task automatic m_cmp;
    int c;
    thr = (mr[4] & 8'h0F) << 8 | mr[3];
    c = res > thr;
    if (c && !cmp) rs = 1;
    if (!c && cmp) fl = 1;
    cmp = c;
  endtask
  function automatic int exp_reg(input int a);
    case (a)
      0, 1, 2, 3, 4: return mr[a];
      5: return res & 8'hFF;
      6: return res >> 8;
      7: return fl << 6 | rs << 5 | dn << 4 | en;
      default: return 0;
    endcase
  endfunction

  // ------------------------------------------------------------
  // stimulus helpers
  // ------------------------------------------------------------
  task automatic irq_chk;
    repeat (6) @(posedge clk);
    #1;
    `CHK("irq_n", !((en[1] && (rs || fl)) || (en[0] && dn)), irq_n)
  endtask
  task automatic wr(input int cmd, input int v);
    u_host.wr(cmd[7:0], v[7:0], 1'b1);
    if ((cmd & 15) < 5) mr[cmd & 15] = v;
    if ((cmd & 15) == 4) mr[4] = v & 8'h0F;
    if ((cmd & 15) == 7) en = v & 3;
    m_cmp();
  endtask
  task automatic clr(input int cmd);
    u_host.wr(cmd[7:0], 8'h00, 1'b0);
    if (cmd & 8'h40) begin
      rs = 0;
      fl = 0;
    end
    if (cmd & 8'h20) dn = 0;
    if (cmd & 8'h10) m_rst();
    irq_chk();
  endtask
  task automatic rd_chk(input int a);
    u_host.rd(8'h80 | a[7:0], d);
    `CHK("reg", exp_reg(a), d)
  endtask
  // one-cycle conversion strobe with its result
  task automatic conv_in(input int v);
    @(posedge clk);
    #1 conv = {1'b1, v[11:0]};
    @(posedge clk);
    #1 conv.done = 1'b0;
    res = v;
    dn = 1;
    m_cmp();
    irq_chk();
  endtask
  task automatic wrap_up;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // hang guard, well above the expected run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      bad_count++;
      wrap_up();
    end
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    conv = '0;
    m_rst();
    repeat (4) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge clk);
    for (int a = 0; a < 9; a++) rd_chk(a);
    // random data to every address; read-only places must keep their value
    for (int a = 0; a < 8; a++) wr(8'h80 | a, $random(seed) & 8'hFF);
    `CHK("cfg", {mr[0][7:0], mr[1][7:0], mr[2][7:0]}, cfg)
    for (int a = 0; a < 9; a++) rd_chk(a);
    wr(8'h83, 8'h00);
    wr(8'h84, 8'h08);
    wr(8'h87, 3);
    // equal is not above, so the boundary pair toggles the compare
    vals = '{12'h800, 12'h801, 12'h800, 12'h801};
    repeat (8) vals.push_back($random(seed) & 12'hFFF);
    foreach (vals[i]) begin
      conv_in(vals[i]);
      if (i == 5) clr(8'h60);
      for (int a = 5; a < 8; a++) rd_chk(a);
    end
    conv_in(12'hFFF);
    conv_in(12'h000);
    clr(8'h20);
    // sweep both gates, first with threshold flags only, then with done only
    repeat (2) begin
      for (int e = 0; e < 4; e++) begin
        wr(8'h87, e);
        irq_chk();
      end
      clr(8'h40);
      conv_in(12'h000);
    end
    // comparator high at soft reset must not leave a falling flag behind
    conv_in(12'hFFF);
    wr(8'h81, 8'h3C);
    clr(8'h10);
    `CHK("burst", 8'h96, cfg.burst)
    for (int a = 0; a < 9; a++) rd_chk(a);
    `CHK("nack", 0, u_host.nack_cnt)
    wrap_up();
  end
endmodule
